// >>> dfpm_params.svh
// Constants for the drive fault protection monitor
//------------------------------------------------------------------------------
// Function
// - Overspeed held for its time in sensorless-2 or vector blocks output.
// - Vector, deviation trip on: deviation over band for time blocks output.
// - Fitted encoder, checking on: lost line-drive cable raises encoder trip.
// - Fan fault mode 0: fan error blocks output and shows fan trip.
// - Fan fault mode 1: fan error drives outputs set to code 8, run on.
// - In fan warning mode, overheat above threshold still blocks output.
// - DC link below low-voltage level blocks output, enters low-voltage trip.
// - Nonzero low-voltage delay: block at once, declare trip after delay.
// - Low-voltage warning on outputs set to code 11 at once, no delay.
//------------------------------------------------------------------------------
`ifndef DFPM_PARAMS_SVH
`define DFPM_PARAMS_SVH

// Register byte offsets
`define DFPM_REG_CTRL 8'h00
`define DFPM_REG_OS_LEVEL 8'h04
`define DFPM_REG_OS_TIME 8'h08
`define DFPM_REG_DEV_BAND 8'h0c
`define DFPM_REG_DEV_TIME 8'h10
`define DFPM_REG_ENC_TIME 8'h14
`define DFPM_REG_UNDERVOLT_TRIP_DELAY 8'h18
`define DFPM_REG_OUT_FUNC 8'h1c
`define DFPM_REG_OH_LEVEL 8'h20
`define DFPM_REG_STATUS 8'h24

// Control register fields
`define DFPM_CTRL_MODE_LSB 0
`define DFPM_CTRL_DEV_EN 2
`define DFPM_CTRL_ENC_EN 3
`define DFPM_CTRL_FAN_MODE 4
`define DFPM_CTRL_RESET 32'h0000_000f

// Status register fields: latched trips, then live levels
`define DFPM_ST_OS 0
`define DFPM_ST_DEV 1
`define DFPM_ST_ENC 2
`define DFPM_ST_FAN 3
`define DFPM_ST_OH 4
`define DFPM_ST_LV 5
`define DFPM_ST_BLOCK 8
`define DFPM_ST_LV_WARN 9
`define DFPM_ST_FAN_WARN 10

// Output function codes
`define DFPM_FUNC_FAN 6'h08
`define DFPM_FUNC_LV 6'h0b
`define DFPM_FUNC_WIDTH 6

// Speed in 0.01 Hz units, then the heatsink temperature level
`define DFPM_OS_LEVEL_DEF 16'h2ee0
`define DFPM_DEV_BAND_DEF 16'h07d0
`define DFPM_OH_LEVEL_DEF 8'h5a

// Times, and their counts in control ticks
`define DFPM_TICK_US 1000
`define DFPM_OS_TIME_MS 10
`define DFPM_DEV_TIME_MS 1000
`define DFPM_ENC_TIME_MS 1000
`define DFPM_LVT_TIME_MS 0
`define DFPM_OS_TICKS ((`DFPM_OS_TIME_MS * 1000) / `DFPM_TICK_US)
`define DFPM_DEV_TICKS ((`DFPM_DEV_TIME_MS * 1000) / `DFPM_TICK_US)
`define DFPM_ENC_TICKS ((`DFPM_ENC_TIME_MS * 1000) / `DFPM_TICK_US)
`define DFPM_LVT_TICKS ((`DFPM_LVT_TIME_MS * 1000) / `DFPM_TICK_US)

`endif

// >>> dfpm_pkg.sv
// Types for the drive fault protection monitor
`default_nettype none
package dfpm_pkg;
   // Drive control modes, in register code order
   typedef enum logic [1:0] {
      DFPM_VF,
      DFPM_SENSORLESS1,
      DFPM_SENSORLESS2,
      DFPM_VECTOR
   } dfpm_mode_type;

   typedef logic [15:0] dfpm_ticks_type;
endpackage : dfpm_pkg
`default_nettype wire

// >>> dfpm_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module dfpm_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   //---------------------------------------------------------------------------
   // Per-bit double flop
   //---------------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta;
         // First stage feeds only the second
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta <= 1'b0;
               dout[i] <= 1'b0;
            end else begin
               meta <= din[i];
               dout[i] <= meta;
            end
         end
      end
   endgenerate
endmodule : dfpm_sync
`default_nettype wire

// >>> dfpm_qual_timer.sv
// Tick-based qualification timer for one fault condition
`timescale 1ns/10ps
`default_nettype none
module dfpm_qual_timer
   import dfpm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic cond,
   input wire dfpm_ticks_type limit,
   output logic expired
);
   dfpm_ticks_type cnt;

   //---------------------------------------------------------------------------
   // Elapsed ticks
   //---------------------------------------------------------------------------
   // Saturates so a long fault never wraps back to zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
      end else if (!cond) begin
         cnt <= '0;
      end else if (tick && (cnt != 16'hffff)) begin
         cnt <= cnt + 16'h0001;
      end
   end

   // Zero limit qualifies at once
   assign expired = cond && (cnt >= limit);

   chk_cnt_restart: assert property (@(posedge clk) disable iff (!rst_n)
      !cond |=> (cnt == '0))
      else $error("qualification count not restarted");
endmodule : dfpm_qual_timer
`default_nettype wire

// >>> dfpm_top.sv
// Drive fault protection monitor with Wishbone register access
//
// The implementer's own choices: the register offsets and register access over Wishbone.
`include "dfpm_params.svh"
`timescale 1ns/10ps
`default_nettype none
module dfpm_top
   import dfpm_pkg::*;
#(
   parameter int SPEED_W = 16,
   parameter int TEMP_W = 8,
   parameter int NUM_OUT = 3
) (
   input wire logic clk,
   input wire logic rst_n,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Drive controller side, same clock
   input wire logic ctrl_tick,
   input wire logic [SPEED_W-1:0] motor_speed,
   input wire logic [SPEED_W-1:0] speed_ref,
   input wire logic [TEMP_W-1:0] heatsink_temp,
   // Pins from motor, encoder, fan and supply
   input wire logic enc_module_present,
   input wire logic enc_cable_loss,
   input wire logic fan_error,
   input wire logic dc_link_low,
   // Protection results
   output logic output_block,
   output logic fault_trip,
   output logic [NUM_OUT-1:0] digital_output
);
   //---------------------------------------------------------------------------
   // Pin synchronisation
   //---------------------------------------------------------------------------
   logic enc_present_s;
   logic enc_loss_s;
   logic fan_err_s;
   logic lv_s;

   dfpm_sync #(.WIDTH(4)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .din({enc_module_present, enc_cable_loss, fan_error, dc_link_low}),
      .dout({enc_present_s, enc_loss_s, fan_err_s, lv_s})
   );

   //---------------------------------------------------------------------------
   // Configuration registers
   //---------------------------------------------------------------------------
   logic [31:0] ctrl;
   logic [SPEED_W-1:0] os_level;
   dfpm_ticks_type os_time;
   logic [SPEED_W-1:0] dev_band;
   dfpm_ticks_type dev_time;
   dfpm_ticks_type enc_time;
   dfpm_ticks_type undervolt_trip_delay;
   logic [31:0] out_func;
   logic [TEMP_W-1:0] oh_level;
   logic [7:0] trip;
   logic wr_en;
   logic rd_en;

   dfpm_mode_type mode;
   logic dev_en;
   logic enc_en;
   logic fan_mode;

   assign mode = dfpm_mode_type'(ctrl[`DFPM_CTRL_MODE_LSB +: 2]);
   assign dev_en = ctrl[`DFPM_CTRL_DEV_EN];
   assign enc_en = ctrl[`DFPM_CTRL_ENC_EN];
   assign fan_mode = ctrl[`DFPM_CTRL_FAN_MODE];

   // A request is taken once, in the cycle before ack
   assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

   // Byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wdat,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = wdat[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // Register writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `DFPM_CTRL_RESET;
         os_level <= SPEED_W'(`DFPM_OS_LEVEL_DEF);
         os_time <= 16'(`DFPM_OS_TICKS);
         dev_band <= SPEED_W'(`DFPM_DEV_BAND_DEF);
         dev_time <= 16'(`DFPM_DEV_TICKS);
         enc_time <= 16'(`DFPM_ENC_TICKS);
         undervolt_trip_delay <= 16'(`DFPM_LVT_TICKS);
         out_func <= '0;
         oh_level <= TEMP_W'(`DFPM_OH_LEVEL_DEF);
      end else if (wr_en) begin
         unique case (wb_adr_i)
            `DFPM_REG_CTRL: begin
               ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) & 32'h0000_001f;
            end
            `DFPM_REG_OS_LEVEL: begin
               os_level <= SPEED_W'(merge(32'(os_level), wb_dat_i, wb_sel_i));
            end
            `DFPM_REG_OS_TIME: begin
               os_time <= 16'(merge(32'(os_time), wb_dat_i, wb_sel_i));
            end
            `DFPM_REG_DEV_BAND: begin
               dev_band <= SPEED_W'(merge(32'(dev_band), wb_dat_i, wb_sel_i));
            end
            `DFPM_REG_DEV_TIME: begin
               dev_time <= 16'(merge(32'(dev_time), wb_dat_i, wb_sel_i));
            end
            `DFPM_REG_ENC_TIME: begin
               enc_time <= 16'(merge(32'(enc_time), wb_dat_i, wb_sel_i));
            end
            `DFPM_REG_UNDERVOLT_TRIP_DELAY: begin
               undervolt_trip_delay <= 16'(merge(32'(undervolt_trip_delay), wb_dat_i, wb_sel_i));
            end
            `DFPM_REG_OUT_FUNC: begin
               out_func <= merge(out_func, wb_dat_i, wb_sel_i);
            end
            `DFPM_REG_OH_LEVEL: begin
               oh_level <= TEMP_W'(merge(32'(oh_level), wb_dat_i, wb_sel_i));
            end
            default: begin
            end
         endcase
      end
   end

   //---------------------------------------------------------------------------
   // Fault conditions
   //---------------------------------------------------------------------------
   logic os_cond;
   logic dev_cond;
   logic enc_cond;
   logic [SPEED_W-1:0] speed_err;
   logic os_hit;
   logic dev_hit;
   logic enc_hit;
   logic lv_hit;

   // Absolute speed error without signed arithmetic
   assign speed_err = (motor_speed >= speed_ref) ? (motor_speed - speed_ref)
                                                 : (speed_ref - motor_speed);
   assign os_cond = ((mode == DFPM_SENSORLESS2) || (mode == DFPM_VECTOR))
                    && (motor_speed > os_level);
   assign dev_cond = (mode == DFPM_VECTOR) && dev_en
                     && (speed_err > dev_band);
   assign enc_cond = enc_present_s && enc_en && enc_loss_s;

   dfpm_qual_timer u_os_timer (
      .clk(clk),
      .rst_n(rst_n),
      .tick(ctrl_tick),
      .cond(os_cond),
      .limit(os_time),
      .expired(os_hit)
   );

   dfpm_qual_timer u_dev_timer (
      .clk(clk),
      .rst_n(rst_n),
      .tick(ctrl_tick),
      .cond(dev_cond),
      .limit(dev_time),
      .expired(dev_hit)
   );

   dfpm_qual_timer u_enc_timer (
      .clk(clk),
      .rst_n(rst_n),
      .tick(ctrl_tick),
      .cond(enc_cond),
      .limit(enc_time),
      .expired(enc_hit)
   );

   // Delay only postpones the trip, never the block
   dfpm_qual_timer u_lv_timer (
      .clk(clk),
      .rst_n(rst_n),
      .tick(ctrl_tick),
      .cond(lv_s),
      .limit(undervolt_trip_delay),
      .expired(lv_hit)
   );

   //---------------------------------------------------------------------------
   // Latched trips, write one to clear, set wins
   //---------------------------------------------------------------------------
   logic [7:0] trip_set;
   logic [7:0] trip_clr;

   always_comb begin
      trip_set = '0;
      trip_set[`DFPM_ST_OS] = os_hit;
      trip_set[`DFPM_ST_DEV] = dev_hit;
      trip_set[`DFPM_ST_ENC] = enc_hit;
      trip_set[`DFPM_ST_FAN] = fan_err_s && !fan_mode;
      trip_set[`DFPM_ST_OH] = heatsink_temp > oh_level;
      trip_set[`DFPM_ST_LV] = lv_hit;
   end

   assign trip_clr = (wr_en && (wb_adr_i == `DFPM_REG_STATUS) && wb_sel_i[0])
                     ? wb_dat_i[7:0] : 8'h00;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trip <= '0;
      end else begin
         trip <= (trip & ~trip_clr) | trip_set;
      end
   end

   //---------------------------------------------------------------------------
   // Block, trip and configurable outputs
   //---------------------------------------------------------------------------
   logic fan_warn;
   logic [NUM_OUT-1:0] next_dout;

   // Warning only exists while running on in warning mode
   assign fan_warn = fan_err_s && fan_mode;

   // Live low voltage blocks before the delayed trip is declared
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         output_block <= 1'b0;
         fault_trip <= 1'b0;
      end else begin
         output_block <= (|trip) || (|trip_set) || lv_s;
         fault_trip <= |trip;
      end
   end

   // One function code field per output
   genvar o;
   generate
      for (o = 0; o < NUM_OUT; o++) begin : g_out
         logic [`DFPM_FUNC_WIDTH-1:0] code;
         assign code = out_func[o*8 +: `DFPM_FUNC_WIDTH];
         assign next_dout[o] = ((code == `DFPM_FUNC_FAN) && fan_warn)
                               || ((code == `DFPM_FUNC_LV) && lv_s);
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         digital_output <= '0;
      end else begin
         digital_output <= next_dout;
      end
   end

   //---------------------------------------------------------------------------
   // Bus answer
   //---------------------------------------------------------------------------
   logic [31:0] next_rdata;

   // Unmapped addresses read zero and still acknowledge
   always_comb begin
      next_rdata = '0;
      unique case (wb_adr_i)
         `DFPM_REG_CTRL: next_rdata = ctrl;
         `DFPM_REG_OS_LEVEL: next_rdata = 32'(os_level);
         `DFPM_REG_OS_TIME: next_rdata = 32'(os_time);
         `DFPM_REG_DEV_BAND: next_rdata = 32'(dev_band);
         `DFPM_REG_DEV_TIME: next_rdata = 32'(dev_time);
         `DFPM_REG_ENC_TIME: next_rdata = 32'(enc_time);
         `DFPM_REG_UNDERVOLT_TRIP_DELAY: next_rdata = 32'(undervolt_trip_delay);
         `DFPM_REG_OUT_FUNC: next_rdata = out_func & 32'h003f_3f3f;
         `DFPM_REG_OH_LEVEL: next_rdata = 32'(oh_level);
         `DFPM_REG_STATUS: begin
            next_rdata[7:0] = trip;
            next_rdata[`DFPM_ST_BLOCK] = output_block;
            next_rdata[`DFPM_ST_LV_WARN] = lv_s;
            next_rdata[`DFPM_ST_FAN_WARN] = fan_warn;
         end
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wr_en || rd_en;
         wb_dat_o <= rd_en ? next_rdata : 32'h0000_0000;
      end
   end

   //---------------------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_lv_onset;
      $rose(lv_s);
   endsequence

   sequence s_lv_held;
      lv_s [*2];
   endsequence

   chk_os_mode_gate: assert property ($rose(trip[`DFPM_ST_OS]) |->
      $past(mode == DFPM_SENSORLESS2 || mode == DFPM_VECTOR))
      else $error("overspeed trip outside its control modes");

   chk_dev_vector_only: assert property ($rose(trip[`DFPM_ST_DEV]) |->
      $past(mode == DFPM_VECTOR && dev_en))
      else $error("deviation trip without vector mode and enable");

   chk_enc_needs_module: assert property ($rose(trip[`DFPM_ST_ENC])
      |-> $past(enc_present_s && enc_en && enc_loss_s))
      else $error("encoder trip without fitted checked module");

   chk_fan_trip_mode: assert property ((fan_err_s && !fan_mode) |=>
      trip[`DFPM_ST_FAN] ##1 output_block)
      else $error("fan error in trip mode did not block");

   chk_fan_warn_out: assert property ((fan_err_s && fan_mode &&
      out_func[5:0] == `DFPM_FUNC_FAN) |=> digital_output[0]
      && !$rose(trip[`DFPM_ST_FAN]))
      else $error("fan warning output wrong");

   chk_overheat_block: assert property ((heatsink_temp > oh_level) |=>
      output_block && trip[`DFPM_ST_OH])
      else $error("overheat did not block output");

   chk_lv_block_now: assert property (s_lv_onset |=> output_block)
      else $error("low voltage did not block at once");

   chk_lv_trip_delay: assert property ($rose(trip[`DFPM_ST_LV]) |->
      $past(lv_s) && ($past(undervolt_trip_delay) == '0 || $past(lv_s, 2)))
      else $error("low voltage trip declared before its delay");

   chk_lv_warn_now: assert property ((s_lv_held and
      (out_func[13:8] == `DFPM_FUNC_LV) [*2]) |=> digital_output[1])
      else $error("low voltage warning delayed");

   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
endmodule : dfpm_top
`default_nettype wire

// >>> dfpm_motor_model.sv
// Far-side model: drive controller tick, motor, encoder, fan and supply
`timescale 1ns/10ps
`default_nettype none
module dfpm_motor_model #(
   parameter int TICK_DIV = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] cmd_speed,
   input wire logic [15:0] cmd_ref,
   input wire logic [7:0] cmd_temp,
   input wire logic cmd_present,
   input wire logic cmd_loss,
   input wire logic cmd_fan,
   input wire logic cmd_low,
   output logic ctrl_tick,
   output logic [15:0] motor_speed,
   output logic [15:0] speed_ref,
   output logic [7:0] heatsink_temp,
   output logic enc_module_present,
   output logic enc_cable_loss,
   output logic fan_error,
   output logic dc_link_low
);
   logic [7:0] tick_cnt;

   //---------------------------------------------------------------------
   // Control tick
   //---------------------------------------------------------------------
   // Short tick period keeps qualification runs brief
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= 8'h00;
         ctrl_tick <= 1'b0;
      end else begin
         tick_cnt <= (tick_cnt == 8'(TICK_DIV - 1)) ? 8'h00 : tick_cnt + 8'h01;
         ctrl_tick <= (tick_cnt == 8'(TICK_DIV - 1));
      end
   end

   //---------------------------------------------------------------------
   // Motor, encoder, fan and supply levels
   //---------------------------------------------------------------------
   // One register stage, as a real sensor path would add
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         motor_speed <= 16'h0000;
         speed_ref <= 16'h0000;
         heatsink_temp <= 8'h00;
         enc_module_present <= 1'b0;
         enc_cable_loss <= 1'b0;
         fan_error <= 1'b0;
         dc_link_low <= 1'b0;
      end else begin
         motor_speed <= cmd_speed;
         speed_ref <= cmd_ref;
         heatsink_temp <= cmd_temp;
         enc_module_present <= cmd_present;
         enc_cable_loss <= cmd_loss;
         fan_error <= cmd_fan;
         dc_link_low <= cmd_low;
      end
   end
endmodule : dfpm_motor_model
`default_nettype wire

// >>> drive_fault_protection_monitor_test.sv
// Self-checking bench for the drive fault protection monitor
`include "dfpm_params.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; \
   if ((got) !== (ex)) begin error_cnt++; \
   $display("BAD %s exp %h got %h", nm, ex, got); end end
module drive_fault_protection_monitor_test;
   import dfpm_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_dat = 32'h0, wb_dat_o, rd;
   logic [3:0] wb_sel = 4'h0;
   logic wb_ack_o, ctrl_tick, output_block, fault_trip;
   logic [15:0] sp = 16'h0, rf = 16'h0, motor_speed, speed_ref;
   logic [7:0] tp = 8'h0, heatsink_temp;
   logic pr = 1'b0, ls = 1'b0, fn = 1'b0, lw = 1'b0;
   logic enc_module_present, enc_cable_loss, fan_error, dc_link_low;
   logic [2:0] digital_output;
   int error_cnt = 0, cmp_count = 0, cyc_cnt = 0;

   //---------------------------------------------------------------------
   // Clock, far side and design
   //---------------------------------------------------------------------
   initial begin
      forever #20 clk = ~clk;
   end
   dfpm_motor_model #(.TICK_DIV(4)) partner (.clk(clk), .rst_n(rst_n),
      .cmd_speed(sp), .cmd_ref(rf), .cmd_temp(tp), .cmd_present(pr),
      .cmd_loss(ls), .cmd_fan(fn), .cmd_low(lw), .ctrl_tick(ctrl_tick),
      .motor_speed(motor_speed), .speed_ref(speed_ref),
      .heatsink_temp(heatsink_temp), .enc_module_present(enc_module_present),
      .enc_cable_loss(enc_cable_loss), .fan_error(fan_error),
      .dc_link_low(dc_link_low));
   dfpm_top DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .ctrl_tick(ctrl_tick), .motor_speed(motor_speed),
      .speed_ref(speed_ref), .heatsink_temp(heatsink_temp),
      .enc_module_present(enc_module_present),
      .enc_cable_loss(enc_cable_loss), .fan_error(fan_error),
      .dc_link_low(dc_link_low), .output_block(output_block),
      .fault_trip(fault_trip), .digital_output(digital_output));

   //---------------------------------------------------------------------
   // Tasks
   //---------------------------------------------------------------------
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   // Classic cycle: hold everything until ack is seen at an edge
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      wb_sel <= 4'hf;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (n >= 50) begin
         error_cnt++;
         $display("BAD bus ack missing at %h", a);
         stop_test();
      end
   endtask : wb

   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask : cycles

   // Remove every cause, then clear sticky trips
   task automatic clr();
      sp <= 16'h0;
      rf <= 16'h0;
      tp <= 8'h0;
      pr <= 1'b0;
      ls <= 1'b0;
      fn <= 1'b0;
      lw <= 1'b0;
      cycles(8);
      wb(1'b1, `DFPM_REG_STATUS, 32'h3f);
      cycles(4);
      `CHK("trip_clr", 1'b0, fault_trip)
      `CHK("block_clr", 1'b0, output_block)
   endtask : clr

   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         stop_test();
      end
   end

   //---------------------------------------------------------------------
   // Scenarios
   //---------------------------------------------------------------------
   initial begin
      cycles(12);
      rst_n <= 1'b1;
      wb(1'b0, `DFPM_REG_CTRL, 32'h0);
      `CHK("ctrl_rst", `DFPM_CTRL_RESET, rd)
      wb(1'b0, `DFPM_REG_OS_LEVEL, 32'h0);
      `CHK("os_level", 32'(`DFPM_OS_LEVEL_DEF), rd)
      wb(1'b0, `DFPM_REG_OS_TIME, 32'h0);
      `CHK("os_time", 32'(`DFPM_OS_TICKS), rd)
      wb(1'b0, `DFPM_REG_DEV_BAND, 32'h0);
      `CHK("dev_band", 32'(`DFPM_DEV_BAND_DEF), rd)
      wb(1'b0, `DFPM_REG_UNDERVOLT_TRIP_DELAY, 32'h0);
      `CHK("undervolt_trip_delay", 32'h0, rd)
      wb(1'b0, 8'hfc, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      wb(1'b1, `DFPM_REG_OUT_FUNC, 32'h0000_0b08);
      // Short qualification times so each run stays small
      wb(1'b1, `DFPM_REG_OS_TIME, 32'h3);
      wb(1'b1, `DFPM_REG_DEV_TIME, 32'h3);
      wb(1'b1, `DFPM_REG_ENC_TIME, 32'h3);
      // Low voltage, no delay: block and trip together, warning output
      lw <= 1'b1;
      cycles(8);
      `CHK("lv_block", 1'b1, output_block)
      `CHK("lv_trip", 1'b1, fault_trip)
      `CHK("lv_warn", 3'b010, digital_output)
      clr();
      // Low voltage with delay: block first, trip only after delay
      wb(1'b1, `DFPM_REG_UNDERVOLT_TRIP_DELAY, 32'h5);
      lw <= 1'b1;
      cycles(6);
      `CHK("lvd_block", 1'b1, output_block)
      `CHK("lvd_early", 1'b0, fault_trip)
      `CHK("lvd_warn", 3'b010, digital_output)
      cycles(30);
      `CHK("lvd_trip", 1'b1, fault_trip)
      wb(1'b0, `DFPM_REG_STATUS, 32'h0);
      `CHK("lvd_stat", 32'h20, rd & 32'h3f)
      clr();
      // Fan fault in trip mode
      fn <= 1'b1;
      cycles(8);
      `CHK("fan_block", 1'b1, output_block)
      wb(1'b0, `DFPM_REG_STATUS, 32'h0);
      `CHK("fan_stat", 32'h08, rd & 32'h3f)
      clr();
      // Fan fault in warning mode, then overheat still blocks
      wb(1'b1, `DFPM_REG_CTRL, 32'h1f);
      fn <= 1'b1;
      tp <= `DFPM_OH_LEVEL_DEF;
      cycles(8);
      `CHK("fanw_out", 3'b001, digital_output)
      `CHK("fanw_run", 1'b0, output_block)
      `CHK("fanw_trip", 1'b0, fault_trip)
      tp <= `DFPM_OH_LEVEL_DEF + 8'h01;
      cycles(8);
      `CHK("oh_block", 1'b1, output_block)
      wb(1'b0, `DFPM_REG_STATUS, 32'h0);
      `CHK("oh_stat", 32'h10, rd & 32'h3f)
      clr();
      // Overspeed in each control mode
      for (int m = 0; m < 4; m++) begin
         wb(1'b1, `DFPM_REG_CTRL, 32'(m));
         sp <= `DFPM_OS_LEVEL_DEF + 16'h1;
         rf <= `DFPM_OS_LEVEL_DEF + 16'h1;
         cycles(40);
         wb(1'b0, `DFPM_REG_STATUS, 32'h0);
         `CHK("os_mode", (m >= 2), rd[0])
         `CHK("os_block", (m >= 2), output_block)
         clr();
      end
      // Level exactly at threshold, and broken bursts, never trip
      sp <= `DFPM_OS_LEVEL_DEF;
      rf <= `DFPM_OS_LEVEL_DEF;
      cycles(40);
      `CHK("os_equal", 1'b0, fault_trip)
      for (int k = 0; k < 4; k++) begin
         sp <= `DFPM_OS_LEVEL_DEF + 16'h1;
         cycles(8);
         sp <= `DFPM_OS_LEVEL_DEF;
         cycles(8);
      end
      `CHK("os_restart", 1'b0, fault_trip)
      clr();
      // Deviation over every mode with trip select off and on
      for (int c = 0; c < 8; c++) begin
         wb(1'b1, `DFPM_REG_CTRL, 32'(c));
         sp <= 16'd3001;
         rf <= 16'd1000;
         cycles(40);
         wb(1'b0, `DFPM_REG_STATUS, 32'h0);
         `CHK("dev_mode", (c == 7), rd[1])
         clr();
      end
      // Encoder cable loss with and without a fitted module
      wb(1'b1, `DFPM_REG_CTRL, 32'h0f);
      pr <= 1'b1;
      ls <= 1'b1;
      cycles(40);
      wb(1'b0, `DFPM_REG_STATUS, 32'h0);
      `CHK("enc_trip", 32'h04, rd & 32'h3f)
      clr();
      ls <= 1'b1;
      cycles(40);
      `CHK("enc_absent", 1'b0, fault_trip)
      clr();
      // Fitted module with checking switched off never trips
      wb(1'b1, `DFPM_REG_CTRL, 32'h07);
      pr <= 1'b1;
      ls <= 1'b1;
      cycles(40);
      `CHK("enc_off", 1'b0, fault_trip)
      clr();
      stop_test();
   end
endmodule : drive_fault_protection_monitor_test
`default_nettype wire
